// ===== rxe_evt_enc.sv
// rxe_evt_enc: builds the event word for one finished frame.
// purely combinational; the caller registers the result.
`default_nettype none
module rxe_evt_enc (
    // frame outcome
    input  wire logic [10:0] len_i,
    input  wire logic        crc_bad_i,
    input  wire logic        dribble_i,
    input  wire logic        bcast_i,
    input  wire logic        station_i,
    input  wire logic        hash_acc_i,
    input  wire logic        station_hash_i,
    input  wire logic [5:0]  hash_idx_i,
    // encoded word and class bits
    output logic      [15:0] word_o,
    output logic             good_o,
    output logic             short_o,
    output logic             over_o
);
    always_comb begin
        short_o = (len_i < rxe_pkg::MIN_LEN);
        over_o  = (len_i > rxe_pkg::MAX_LEN);
        good_o  = !crc_bad_i && !short_o && !over_o;
        word_o  = {10'h000, rxe_pkg::EVT_ID};
        word_o[rxe_pkg::EVT_SHASH] = station_hash_i;
        word_o[rxe_pkg::EVT_DRIB]  = dribble_i;
        word_o[rxe_pkg::EVT_GOOD]  = good_o;
        word_o[rxe_pkg::EVT_HASH]  = hash_acc_i;
        if (good_o && hash_acc_i) begin
            // accepted by hash: upper bits carry the table index instead
            word_o[15:10] = hash_idx_i;
        end else begin
            word_o[rxe_pkg::EVT_STAT]  = station_i;
            word_o[rxe_pkg::EVT_BCAST] = bcast_i;
            word_o[rxe_pkg::EVT_CRC]   = crc_bad_i;
            word_o[rxe_pkg::EVT_SHORT] = short_o;
            word_o[rxe_pkg::EVT_OVER]  = over_o;
        end
    end
endmodule
`default_nettype wire

// ===== rxe_host.sv
// rxe_host: host model that reaches the register window over axi4-lite.
// assumes one shared clock; the bench calls one task at a time.
`default_nettype none
module rxe_host (
    // clock
    input  wire logic        clk_i,
    // write channels
    output logic      [11:0] aw_o,
    output logic             awv_o,
    input  wire logic        awr_i,
    output logic      [31:0] wd_o,
    output logic      [3:0]  ws_o,
    output logic             wv_o,
    input  wire logic        wr_i,
    output logic             br_o,
    input  wire logic        bv_i,
    input  wire logic [1:0]  bre_i,
    // read channels
    output logic      [11:0] ar_o,
    output logic             arv_o,
    input  wire logic        arr_i,
    output logic             rr_o,
    input  wire logic        rv_i,
    input  wire logic [31:0] rd_i,
    input  wire logic [1:0]  rre_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus from time zero
    initial begin
        {aw_o, awv_o, wd_o, ws_o, wv_o, br_o, ar_o, arv_o, rr_o} = '0;
    end
    // one write; each channel dropped at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        {aw_o, wd_o, ws_o, awv_o, wv_o, br_o} <= {a, d, 4'hF, 3'b111};
        do begin
            @(posedge clk_i);
            if (awr_i) awv_o <= 1'b0;
            if (wr_i) wv_o <= 1'b0;
        end while (!bv_i);
        r = bre_i;
        br_o <= 1'b0;
    endtask
    // one read; the whole word goes back to the caller, nothing filtered
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        {ar_o, arv_o, rr_o} <= {a, 2'b11};
        do begin
            @(posedge clk_i);
            if (arr_i) arv_o <= 1'b0;
        end while (!rv_i);
        d = rd_i;
        r = rre_i;
        rr_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== rxe_len_cnt.sv
// rxe_len_cnt: counts the bytes of the frame in progress.
// assumes byte strobes and the frame end strobe never share a cycle.
`default_nettype none
module rxe_len_cnt #(
    parameter int LEN_W = 11
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    // byte stream
    input  wire logic             byte_vld_i,
    input  wire logic             frame_end_i,
    // count
    output logic      [LEN_W-1:0] len_o
);
    // saturating at all ones keeps an endless frame reading as oversize
    localparam logic [LEN_W-1:0] LEN_SAT = '1;

    initial begin
        if (LEN_W < 11) $error("rxe_len_cnt: LEN_W too small for 1518");
    end

    // count bytes, restart after each frame end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            len_o <= '0;
        end else if (frame_end_i) begin
            len_o <= '0;
        end else if (byte_vld_i && len_o != LEN_SAT) begin
            len_o <= len_o + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== rxe_pkg.sv
// rxe_pkg: register map, field positions, reset values and limits of the
// receive event block.
// assumes a 32-bit AXI4-Lite register bus and byte lengths below 2048.
`default_nettype none
package rxe_pkg;
    // register byte offsets
    localparam logic [11:0] EVT_OFS  = 12'h124; // receive_event_flags, read clears
    localparam logic [11:0] STS_OFS  = 12'h400; // receive_status_copy, read only
    localparam logic [11:0] CFG_OFS  = 12'h102 + 12'h002; // receive_configuration
    localparam logic [11:0] IST_OFS  = 12'h128; // sticky interrupt status, w1c
    localparam logic [11:0] IMSK_OFS = 12'h12C; // interrupt mask
    // reset values and identifying codes
    localparam logic [15:0] EVT_RST  = 16'h0004;
    localparam logic [5:0]  EVT_ID   = 6'h04;
    localparam logic [15:0] CFG_RST  = 16'h0003;
    localparam logic [5:0]  CFG_ID   = 6'h03;
    // receive_configuration bits
    localparam int CFG_GOOD_IE  = 8;
    localparam int CFG_DMA_EXCL = 9;
    localparam int CFG_CRC_IE   = 12;
    localparam int CFG_SHORT_IE = 13;
    localparam int CFG_OVER_IE  = 14;
    // receive_event_flags bits
    localparam int EVT_SHASH = 6;
    localparam int EVT_DRIB  = 7;
    localparam int EVT_GOOD  = 8;
    localparam int EVT_HASH  = 9;
    localparam int EVT_STAT  = 10;
    localparam int EVT_BCAST = 11;
    localparam int EVT_CRC   = 12;
    localparam int EVT_SHORT = 13;
    localparam int EVT_OVER  = 14;
    // sticky interrupt status bits
    localparam int IRQ_GOOD  = 0;
    localparam int IRQ_CRC   = 1;
    localparam int IRQ_SHORT = 2;
    localparam int IRQ_OVER  = 3;
    localparam int IRQ_W     = 4;
    // frame length limits in bytes
    localparam logic [10:0] MAX_LEN     = 11'h5EE; // 1518
    localparam logic [10:0] MIN_LEN     = 11'h040; // 64
    localparam logic [10:0] DISCARD_LEN = 11'h008; // 8
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // read channel states
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rxe_rd_st_t;
endpackage
`default_nettype wire

// ===== rxe_top.sv
// rxe_top: receive event and status registers with interrupt logic,
// reached over AXI4-Lite.
// assumes the receive engine gives byte strobes and a frame end strobe
// with the frame's outcome held valid in that cycle.
//
// Contract
// - event register resets 0x0004, low id 000100
// - event register at 0x124, writes ignored
// - reading event register clears its event bits
// - status copy at 0x400, not cleared
// - oversize flag for frames above 1518 bytes
// - keep only the first 1518 bytes
// - oversize flag with enable raises interrupt
// - bad checksum flag, interrupt when enabled
// - short flag below 64, interrupt when enabled
// - frames under 8 bytes always discarded
// - good flag, interrupt unless dma-only
//
// Register access over AXI4-Lite was chosen for this implementation.
`default_nettype none
module rxe_top #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              resetn_i,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    // axi4-lite write response
    output logic      [1:0]        s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic      [31:0]       s_axi_rdata_o,
    output logic      [1:0]        s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // receive engine
    input  wire logic              rx_byte_vld_i,
    input  wire logic              rx_frame_end_i,
    input  wire logic              rx_crc_bad_i,
    input  wire logic              rx_dribble_i,
    input  wire logic              rx_bcast_i,
    input  wire logic              rx_station_i,
    input  wire logic              rx_hash_acc_i,
    input  wire logic              rx_station_hash_i,
    input  wire logic [5:0]        rx_hash_idx_i,
    // results
    output logic                   rx_byte_keep_o,
    output logic                   rx_frame_drop_o,
    output logic                   irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    initial begin
        // the decode compares twelve address bits, so narrower buses cannot be served
        if (ADDR_W < 12) $error("rxe_top: ADDR_W below 12 bits");
    end

    logic [15:0]         evt_r;       // receive_event_flags
    logic [15:0]         sts_r;       // receive_status_copy
    logic [15:0]         cfg_r;       // receive_configuration
    localparam int IRQW = rxe_pkg::IRQ_W;
    logic [IRQW-1:0]     ist_r;       // sticky interrupt status
    logic [IRQW-1:0]     msk_r;       // interrupt mask
    logic [10:0]         len;         // bytes of frame in progress
    logic [15:0]         word;        // encoded event word
    logic                good;        // frame without error
    logic                short_f;     // under 64 bytes
    logic                over_f;      // above 1518 bytes
    logic                upd;         // frame end of a kept frame
    logic [IRQW-1:0]     ev_set;      // interrupt events this cycle

    // length of the frame being received
    rxe_len_cnt #(
        .LEN_W (11)
    ) u_len (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .byte_vld_i  (rx_byte_vld_i),
        .frame_end_i (rx_frame_end_i),
        .len_o       (len)
    );

    // event word of the frame that ends now
    rxe_evt_enc u_enc (
        .len_i          (len),
        .crc_bad_i      (rx_crc_bad_i),
        .dribble_i      (rx_dribble_i),
        .bcast_i        (rx_bcast_i),
        .station_i      (rx_station_i),
        .hash_acc_i     (rx_hash_acc_i),
        .station_hash_i (rx_station_hash_i),
        .hash_idx_i     (rx_hash_idx_i),
        .word_o         (word),
        .good_o         (good),
        .short_o        (short_f),
        .over_o         (over_f)
    );

    // frames under 8 bytes leave no trace in the registers, only the drop strobe
    assign upd = rx_frame_end_i && (len >= rxe_pkg::DISCARD_LEN);

    // bytes past 1518 are not stored; the flag is the storage strobe
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_byte_keep_o <= 1'b0;
        end else begin
            rx_byte_keep_o <= rx_byte_vld_i && (len < rxe_pkg::MAX_LEN);
        end
    end

    // drop strobe for too-short frames
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_frame_drop_o <= 1'b0;
        end else begin
            rx_frame_drop_o <= rx_frame_end_i && !upd;
        end
    end

    // bus write decode
    logic              aw_got_r;   // address held
    logic              w_got_r;    // data held
    logic [ADDR_W-1:0] waddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              wr_go;      // perform write this cycle
    logic              wr_cfg;
    logic              wr_ist;
    logic              wr_msk;
    logic              wr_hit;
    assign wr_go  = aw_got_r && w_got_r && !s_axi_bvalid_o;
    assign wr_cfg = waddr_r[11:0] == rxe_pkg::CFG_OFS;
    assign wr_ist = waddr_r[11:0] == rxe_pkg::IST_OFS;
    assign wr_msk = waddr_r[11:0] == rxe_pkg::IMSK_OFS;
    // event and copy registers accept writes but keep their value
    assign wr_hit = wr_cfg || wr_ist || wr_msk
                 || waddr_r[11:0] == rxe_pkg::EVT_OFS
                 || waddr_r[11:0] == rxe_pkg::STS_OFS;

    // address and data channels taken in either order
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            waddr_r  <= '0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_got_r <= 1'b1;
                waddr_r  <= {s_axi_awaddr_i[ADDR_W-1:2], 2'b00};
            end else if (wr_go) begin
                aw_got_r <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end else if (wr_go) begin
                w_got_r <= 1'b0;
            end
        end
    end

    // readies and response: one write under way at a time
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= rxe_pkg::RESP_OKAY;
        end else begin
            s_axi_awready_o <= !aw_got_r && !(s_axi_awvalid_i && s_axi_awready_o)
                             && !wr_go && !s_axi_bvalid_o;
            s_axi_wready_o  <= !w_got_r && !(s_axi_wvalid_i && s_axi_wready_o)
                             && !wr_go && !s_axi_bvalid_o;
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_hit ? rxe_pkg::RESP_OKAY : rxe_pkg::RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // receive_configuration: low id bits fixed, only strobed lanes change
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_r <= rxe_pkg::CFG_RST;
        end else if (wr_go && wr_cfg) begin
            if (wstrb_r[0]) cfg_r[7:6]  <= wdata_r[7:6];
            if (wstrb_r[1]) cfg_r[15:8] <= wdata_r[15:8];
        end
    end

    // interrupt mask
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            msk_r <= '0;
        end else if (wr_go && wr_msk && wstrb_r[0]) begin
            msk_r <= wdata_r[IRQW-1:0];
        end
    end

    // read channel
    rxe_pkg::rxe_rd_st_t rd_st_r;
    logic                ar_go;     // read request taken now
    logic                rd_evt;    // read of the event register taken
    logic [11:0]         raddr;
    assign ar_go  = s_axi_arvalid_i && s_axi_arready_o;
    assign raddr  = {s_axi_araddr_i[11:2], 2'b00};
    assign rd_evt = ar_go && raddr == rxe_pkg::EVT_OFS;

    // read state and registered data
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_st_r         <= rxe_pkg::RD_IDLE;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= rxe_pkg::RESP_OKAY;
        end else begin
            case (rd_st_r)
                rxe_pkg::RD_IDLE: begin
                    s_axi_arready_o <= !ar_go;
                    if (ar_go) begin
                        rd_st_r        <= rxe_pkg::RD_DATA;
                        s_axi_rvalid_o <= 1'b1;
                        s_axi_rresp_o  <= rxe_pkg::RESP_OKAY;
                        case (raddr)
                            rxe_pkg::EVT_OFS:  s_axi_rdata_o <= {16'h0000, evt_r};
                            rxe_pkg::STS_OFS:  s_axi_rdata_o <= {16'h0000, sts_r};
                            rxe_pkg::CFG_OFS:  s_axi_rdata_o <= {16'h0000, cfg_r};
                            rxe_pkg::IST_OFS:  s_axi_rdata_o <= {28'h0000000, ist_r};
                            rxe_pkg::IMSK_OFS: s_axi_rdata_o <= {28'h0000000, msk_r};
                            default: begin
                                // unmapped: zero data with error answer
                                s_axi_rdata_o <= '0;
                                s_axi_rresp_o <= rxe_pkg::RESP_SLVERR;
                            end
                        endcase
                    end
                end
                rxe_pkg::RD_DATA: begin
                    if (s_axi_rready_i) begin
                        rd_st_r         <= rxe_pkg::RD_IDLE;
                        s_axi_rvalid_o  <= 1'b0;
                        s_axi_arready_o <= 1'b1;
                    end
                end
                default: begin
                    rd_st_r <= rxe_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // event register: a new frame wins over the read that clears it,
    // so an event landing in the read cycle is never lost
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            evt_r <= rxe_pkg::EVT_RST;
        end else if (upd) begin
            evt_r <= word;
        end else if (rd_evt) begin
            evt_r <= rxe_pkg::EVT_RST;
        end
    end

    // status copy: same word, untouched by reads
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sts_r <= rxe_pkg::EVT_RST;
        end else if (upd) begin
            sts_r <= word;
        end
    end

    // interrupt events gated by the configuration enables
    always_comb begin
        ev_set = '0;
        if (upd) begin
            // good frames do not interrupt while receive is dma-only
            ev_set[rxe_pkg::IRQ_GOOD]  = good && cfg_r[rxe_pkg::CFG_GOOD_IE]
                                      && !cfg_r[rxe_pkg::CFG_DMA_EXCL];
            ev_set[rxe_pkg::IRQ_CRC]   = rx_crc_bad_i && cfg_r[rxe_pkg::CFG_CRC_IE];
            ev_set[rxe_pkg::IRQ_SHORT] = short_f && cfg_r[rxe_pkg::CFG_SHORT_IE];
            ev_set[rxe_pkg::IRQ_OVER]  = over_f && cfg_r[rxe_pkg::CFG_OVER_IE];
        end
    end

    // sticky status: write one clears, a set in the same cycle wins
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ist_r <= '0;
        end else if (wr_go && wr_ist && wstrb_r[0]) begin
            ist_r <= (ist_r & ~wdata_r[IRQW-1:0]) | ev_set;
        end else begin
            ist_r <= ist_r | ev_set;
        end
    end

    // level interrupt, one cycle behind the status
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ist_r & msk_r);
        end
    end

    a_evt_id_bits: assert property (evt_r[5:0] == rxe_pkg::EVT_ID)
        else $error("event id bits wrong");
    a_read_clears: assert property (rd_evt && !upd |=> evt_r == rxe_pkg::EVT_RST)
        else $error("event read did not clear");
    a_copy_kept: assert property (rd_evt && !upd |=> $stable(sts_r))
        else $error("status copy changed on event read");
    a_evt_write_ignored: assert property (
        wr_go && waddr_r[11:0] == rxe_pkg::EVT_OFS && !upd && !rd_evt |=> $stable(evt_r))
        else $error("event register took a write");
    a_over_flag: assert property (upd && len > rxe_pkg::MAX_LEN
        |=> evt_r[rxe_pkg::EVT_OVER] && sts_r[rxe_pkg::EVT_OVER])
        else $error("oversize flag missing");
    a_keep_limit: assert property (rx_byte_vld_i && len >= rxe_pkg::MAX_LEN
        |=> !rx_byte_keep_o)
        else $error("byte beyond limit kept");
    a_over_irq: assert property (upd && over_f && cfg_r[rxe_pkg::CFG_OVER_IE]
        && msk_r[rxe_pkg::IRQ_OVER] && !(wr_go && wr_msk) |=> ##1 irq_o)
        else $error("oversize interrupt missing");
    a_crc_irq: assert property (upd && rx_crc_bad_i && cfg_r[rxe_pkg::CFG_CRC_IE]
        |=> ist_r[rxe_pkg::IRQ_CRC])
        else $error("checksum interrupt status missing");
    a_short_flag: assert property (upd && len < rxe_pkg::MIN_LEN
        |=> evt_r[rxe_pkg::EVT_SHORT] && !evt_r[rxe_pkg::EVT_GOOD])
        else $error("short flag missing");
    a_tiny_drop: assert property (rx_frame_end_i && len < rxe_pkg::DISCARD_LEN
        |=> rx_frame_drop_o && $stable(sts_r))
        else $error("tiny frame not discarded");
    a_good_dma: assert property (upd && cfg_r[rxe_pkg::CFG_DMA_EXCL]
        && !ist_r[rxe_pkg::IRQ_GOOD] |=> !ist_r[rxe_pkg::IRQ_GOOD])
        else $error("good interrupt under dma-only");
    a_hash_index: assert property (upd && good && rx_hash_acc_i
        |=> evt_r[15:10] == $past(rx_hash_idx_i) && evt_r[rxe_pkg::EVT_HASH])
        else $error("hash index not reported");
endmodule
`default_nettype wire

// ===== rxe_top_tb_top.sv
// rxe_top_tb_top: self-checking bench for the receive event block.
// assumes rxe_pkg, rxe_top and the host model rxe_host compiled first.
`default_nettype none
module rxe_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // bus, receive link and bench state
    logic        clk_sys, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, keep, drop;
    logic        bvld, fend, crc, drib, bc, st, ha, sh;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, ev, cp, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [5:0]  hidx;
    int          fails = 0, checks_done = 0, keeps = 0, drops = 0;
    int          lens[10] = '{64, 7, 8, 63, 1518, 1519, 1520, 100, 10, 1600};
    rxe_top dut (
        .clk_sys_i(clk_sys), .resetn_i(resetn), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .rx_byte_vld_i(bvld), .rx_frame_end_i(fend),
        .rx_crc_bad_i(crc), .rx_dribble_i(drib), .rx_bcast_i(bc), .rx_station_i(st),
        .rx_hash_acc_i(ha), .rx_station_hash_i(sh), .rx_hash_idx_i(hidx),
        .rx_byte_keep_o(keep), .rx_frame_drop_o(drop), .irq_o(irq)
    );
    rxe_host host (
        .clk_i(clk_sys), .aw_o(awaddr), .awv_o(awvalid), .awr_i(awready), .wd_o(wdata),
        .ws_o(wstrb), .wv_o(wvalid), .wr_i(wready), .br_o(bready), .bv_i(bvalid),
        .bre_i(bresp), .ar_o(araddr), .arv_o(arvalid), .arr_i(arready), .rr_o(rready),
        .rv_i(rvalid), .rd_i(rdata), .rre_i(rresp)
    );
    // 20 mhz system clock
    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;
    // count keep and drop pulses as they leave the design
    always @(posedge clk_sys) begin
        keeps <= keeps + int'(keep);
        drops <= drops + int'(drop);
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // reference event word; f = {crc, bcast, station, hash, dribble, station hash}
    function automatic logic [15:0] evt_exp(input int n, input logic [5:0] f,
                                            input logic [5:0] ix);
        logic        g;
        logic [15:0] w;
        g = !f[5] && n >= 64 && n <= 1518;
        w = {1'b0, n > 1518, n < 64, f[5:2], g, f[1:0], 6'h04};
        if (g && f[2]) w[15:10] = ix;
        return w;
    endfunction
    // bytes back to back; outcome lines hold the wrong value until frame end
    task automatic frame(input int n, input logic [5:0] f, input logic [5:0] ix);
        {crc, bc, st, ha, drib, sh} <= ~f;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            bvld <= 1'b1;
        end
        @(posedge clk_sys);
        {bvld, fend, crc, bc, st, ha, drib, sh, hidx} <= {2'b01, f, ix};
        @(posedge clk_sys);
        fend <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // one frame of random outcome and configuration, then the host's view
    task automatic one_frame(input int n);
        logic [31:0] c;
        logic [15:0] w;
        logic [3:0]  ie;
        int          k0;
        int          d0;
        seed = xs(seed);
        c = seed & 32'h0000_7300;
        w = evt_exp(n, seed[5:0], seed[21:16]);
        host.wr(rxe_pkg::CFG_OFS, c, r);
        k0 = keeps;
        d0 = drops;
        frame(n, seed[5:0], seed[21:16]);
        chk("kept bytes", (n > 1518) ? 1518 : n, keeps - k0);
        chk("dropped", n < 8, drops - d0);
        ie = {n > 1518 && c[14], n < 64 && c[13], seed[5] && c[12], w[8] && c[8] && !c[9]};
        if (n < 8) ie = 4'h0;
        else begin
            ev = {16'h0, w};
            cp = {16'h0, w};
        end
        chk("irq", |ie, irq);
        host.rd(rxe_pkg::IST_OFS, d, r);
        chk("irq status", ie, d);
        host.wr(rxe_pkg::IST_OFS, 32'hF, r);
        repeat (2) @(posedge clk_sys);
        chk("irq cleared", 0, irq);
        if (!c[9]) begin // event word not relied on under dma-only
            host.rd(rxe_pkg::EVT_OFS, d, r);
            chk("event", ev, d);
            ev = 32'h4;
            host.rd(rxe_pkg::EVT_OFS, d, r);
            chk("event after read", ev, d);
        end
        host.rd(rxe_pkg::STS_OFS, d, r);
        chk("copy", cp, d);
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, about three times the expected run
    initial begin
        #(60000 * 50);
        fails++;
        wrap_up();
    end
    // main sequence
    initial begin
        {resetn, bvld, fend, crc, drib, bc, st, ha, sh, hidx} = '0;
        seed = 32'hC2C42A25;
        ev = 32'h4;
        cp = 32'h4;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        host.rd(rxe_pkg::EVT_OFS, d, r);
        chk("event at reset", 32'h0000_0004, d);
        host.wr(rxe_pkg::EVT_OFS, 32'hFFFF_FFFF, r);
        chk("event write resp", rxe_pkg::RESP_OKAY, r);
        host.rd(rxe_pkg::EVT_OFS, d, r);
        chk("event after write", 32'h4, d);
        host.rd(12'h200, d, r);
        chk("unmapped resp", rxe_pkg::RESP_SLVERR, r);
        chk("unmapped data", 32'h0000_0000, d);
        host.wr(rxe_pkg::IMSK_OFS, 32'hF, r);
        $display("register tests done");
        for (int i = 0; i < 30; i++) begin
            one_frame(lens[i % 10]);
            $display("frame test %0d of %0d bytes done", i, lens[i % 10]);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
